// file: hw/ram_map_pkg.sv
// Constants for the on-chip RAM, stack and register bank address map
package ram_map_pkg;
  localparam int          ADDR_W        = 21;
  localparam int          SEG_COUNT     = 32;
  localparam int          SEG_BYTES     = 65536;
  localparam int          PAGE_BYTES    = 16384;
  localparam logic [1:0]  RAM_PAGE      = 2'h3;
  localparam int          RAM_BYTES     = 3072;
  localparam int          RAM_WORDS     = RAM_BYTES / 2;
  localparam logic [15:0] RAM_BASE      = 16'hF200;
  localparam logic [15:0] RAM_TOP_WORD  = 16'hFDFE;
  localparam logic [15:0] CODE_TOP_2W   = 16'hFDFC;
  localparam logic [15:0] RAM_BIT_LO    = 16'hFD00;
  localparam logic [15:0] RAM_BIT_HI    = 16'hFDFF;
  localparam logic [15:0] SFR_LO        = 16'hFE00;
  localparam logic [15:0] SFR_BIT_LO    = 16'hFF00;
  localparam logic [15:0] EXTENDED_FUNCTION_REGISTER_LO       = 16'hF000;
  localparam logic [15:0] EXTENDED_FUNCTION_REGISTER_HI       = 16'hF1FF;
  localparam logic [15:0] EXTENDED_FUNCTION_REGISTER_BIT_LO   = 16'hF100;
  localparam logic [15:0] STK_TOP_STD   = 16'hFBFE;
  localparam logic [15:0] STK_TOP_BIG   = 16'hFDFE;
  localparam logic [15:0] STK_BOT_256   = 16'hFA00;
  localparam logic [15:0] STK_BOT_128   = 16'hFB00;
  localparam logic [15:0] STK_BOT_64    = 16'hFB80;
  localparam logic [15:0] STK_BOT_32    = 16'hFBC0;
  localparam logic [15:0] STK_BOT_512   = 16'hF800;
  localparam logic [15:0] STK_BOT_1024  = 16'hF600;
  localparam logic [2:0]  STKSZ_256     = 3'h0;
  localparam logic [2:0]  STKSZ_128     = 3'h1;
  localparam logic [2:0]  STKSZ_64      = 3'h2;
  localparam logic [2:0]  STKSZ_32      = 3'h3;
  localparam logic [2:0]  STKSZ_512     = 3'h4;
  localparam logic [2:0]  STKSZ_1024    = 3'h7;
  localparam logic [2:0]  STKSZ_RESET   = 3'h0;
  localparam logic [15:0] BANK_RESET    = 16'hFC00;
  localparam logic [15:0] BANK_LAST_OFS = 16'h001E;
  localparam int          PROT_BITS     = 33;
  typedef enum logic [1:0] {
    ACC_BYTE, ACC_WORD, ACC_BIT
  } acc_size_t;
  typedef enum logic [1:0] {
    SRC_DATA, SRC_EVENT, SRC_STACK, SRC_BANK
  } acc_src_t;
endpackage

// file: hw/stack_limits.sv
// Stack region and limit decoder for the stack size field
`timescale 1ns/100ps
`default_nettype none
module stack_limits
  import ram_map_pkg::*;
(
  input  wire logic [2:0]  size_code,   // Stack size field
  output logic      [15:0] top_addr,    // Highest stack word
  output logic      [15:0] bot_addr,    // Lowest stack word
  output logic      [10:0] size_words,  // Stack size in words
  output logic             circ_ok,     // Circular stack allowed
  output logic             code_bad     // Reserved code used
);
  always_comb begin
    top_addr   = STK_TOP_STD;
    bot_addr   = STK_BOT_256;
    size_words = 11'h100;
    circ_ok    = 1'b1;
    code_bad   = 1'b0;
    case (size_code)
      STKSZ_256: begin
        bot_addr   = STK_BOT_256;
        size_words = 11'h100;
      end
      STKSZ_128: begin
        bot_addr   = STK_BOT_128;
        size_words = 11'h080;
      end
      STKSZ_64: begin
        bot_addr   = STK_BOT_64;
        size_words = 11'h040;
      end
      STKSZ_32: begin
        bot_addr   = STK_BOT_32;
        size_words = 11'h020;
      end
      STKSZ_512: begin
        bot_addr   = STK_BOT_512;
        size_words = 11'h200;
      end
      STKSZ_1024: begin
        top_addr   = STK_TOP_BIG;
        bot_addr   = STK_BOT_1024;
        size_words = 11'h400;
        circ_ok    = 1'b0;
      end
      default: begin
        code_bad = 1'b1;
        circ_ok  = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// file: hw/protect_merge.sv
// Merge of a software write with hardware-owned protected bits
`timescale 1ns/100ps
`default_nettype none
module protect_merge
  import ram_map_pkg::*;
#(
  parameter int WIDTH = PROT_BITS
)(
  input  wire logic [WIDTH-1:0] cur_val,   // Present bit values
  input  wire logic [WIDTH-1:0] sw_data,   // Software write data
  input  wire logic [WIDTH-1:0] sw_sel,    // Bits software targets
  input  wire logic             sw_wr,     // Software write strobe
  input  wire logic [WIDTH-1:0] hw_set,    // Hardware set events
  input  wire logic [WIDTH-1:0] hw_clr,    // Hardware clear events
  output logic      [WIDTH-1:0] next_val   // Resulting values
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // Hardware wins, so an event in a write cycle is lost only when a clear meets a set
      always_comb begin
        if (hw_set[i])
          next_val[i] = 1'b1;
        else if (hw_clr[i])
          next_val[i] = 1'b0;
        else if (sw_wr && sw_sel[i])
          next_val[i] = sw_data[i];
        else
          next_val[i] = cur_val[i];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: hw/ram_stack_bank_map.sv
// On-chip RAM with address map, system stack and register banks
`timescale 1ns/100ps
`default_nettype none
module ram_stack_bank_map
  import ram_map_pkg::*;
#(
  parameter int WORDS = RAM_WORDS
)(
  input  wire logic             clk,          // Core clock
  input  wire logic             rst,          // Sync reset, active high
  input  wire logic             acc_req,      // Access request
  input  wire logic             acc_wr,       // Write when high
  input  wire logic [1:0]       acc_src,      // Access source kind
  input  wire logic [1:0]       acc_size,     // Byte, word or bit
  input  wire logic             acc_fetch,    // Instruction fetch
  input  wire logic             acc_dbl,      // Two-word code item
  input  wire logic [15:0]      acc_addr,     // Byte address or offset
  input  wire logic [1:0]       acc_page_sel, // Page pointer index
  input  wire logic [3:0]       acc_bit,      // Bit position
  input  wire logic [15:0]      acc_wdata,    // Write data
  input  wire logic [4:0]       reg_num,      // Bank reg or byte reg
  input  wire logic [9:0]       page_ptr0,    // Data page pointer 0
  input  wire logic [9:0]       page_ptr1,    // Data page pointer 1
  input  wire logic [9:0]       page_ptr2,    // Data page pointer 2
  input  wire logic [9:0]       page_ptr3,    // Data page pointer 3
  input  wire logic             push,         // Push a word
  input  wire logic             pop,          // Pop a word
  input  wire logic [15:0]      push_data,    // Word to push
  input  wire logic             sp_wr,        // Load stack pointer
  input  wire logic [15:0]      sp_wdata,     // New stack pointer
  input  wire logic [2:0]       size_code,    // Stack size field
  input  wire logic             lim_wr,       // Load both limits
  input  wire logic [15:0]      low_lim_in,   // New low limit
  input  wire logic [15:0]      high_lim_in,  // New high limit
  input  wire logic             bank_wr,      // Load bank base
  input  wire logic             bank_switch,  // Switch-bank request
  input  wire logic [15:0]      bank_wdata,   // New bank base
  input  wire logic             flag_wr,      // Protected reg write
  input  wire logic [32:0]      flag_wdata,   // Write data for flags
  input  wire logic [32:0]      flag_sel,     // Bits written
  input  wire logic [32:0]      flag_hw_set,  // Hardware set events
  input  wire logic [32:0]      flag_hw_clr,  // Hardware clear events
  output logic                  rd_valid,     // Read data valid
  output logic      [15:0]      rd_data,      // Read data
  output logic                  acc_err,      // Access refused
  output logic                  ram_hit,      // Access reached RAM
  output logic                  bit_ok,       // Bit address allowed
  output logic      [15:0]      stack_top_pointer, // Stack pointer
  output logic      [15:0]      stack_low_limit,   // Low limit
  output logic      [15:0]      stack_high_limit,  // High limit
  output logic                  stack_over,   // Push went below low limit
  output logic                  stack_under,  // Pop passed high limit
  output logic                  stack_circ,   // Circular mode allowed
  output logic                  size_bad,     // Reserved size code
  output logic      [15:0]      bank_base_pointer, // Active bank base
  output logic      [15:0]      saved_bank,   // Previous bank base
  output logic      [32:0]      prot_flags,   // Protected flag bits
  output logic      [ADDR_W-1:0] phys_addr    // Last linear address
);
  typedef struct packed {
    logic              rd_valid;
    logic [15:0]       rd_data;
    logic              acc_err;
    logic              ram_hit;
    logic              bit_ok;
    logic [15:0]       sp;
    logic [15:0]       low_lim;
    logic [15:0]       high_lim;
    logic              over;
    logic              under;
    logic              circ;
    logic              bad;
    logic [15:0]       bank;
    logic [15:0]       saved;
    logic [32:0]       flags;
    logic [ADDR_W-1:0] phys;
  } state_t;

  state_t      s_q;
  state_t      s_d;
  logic [15:0] mem [WORDS];
  logic [15:0] top_a;
  logic [15:0] bot_a;
  logic        circ_a;
  logic        bad_a;
  logic [32:0] flags_n;

  stack_limits u_lim (
    .size_code  (size_code),
    .top_addr   (top_a),
    .bot_addr   (bot_a),
    .size_words (),
    .circ_ok    (circ_a),
    .code_bad   (bad_a)
  );

  protect_merge #(.WIDTH(PROT_BITS)) u_prot (
    .cur_val  (s_q.flags),
    .sw_data  (flag_wdata),
    .sw_sel   (flag_sel),
    .sw_wr    (flag_wr),
    .hw_set   (flag_hw_set),
    .hw_clr   (flag_hw_clr),
    .next_val (flags_n)
  );

  function automatic logic in_ram(input logic [15:0] a);
    return a >= RAM_BASE && a <= RAM_BIT_HI;
  endfunction

  function automatic logic bit_area(input logic [15:0] a);
    // upper 256 bytes of each block
    return (a >= RAM_BIT_LO && a <= RAM_BIT_HI) || a >= SFR_BIT_LO ||
           (a >= EXTENDED_FUNCTION_REGISTER_BIT_LO && a <= EXTENDED_FUNCTION_REGISTER_HI);
  endfunction

  function automatic logic [10:0] widx(input logic [15:0] a);
    logic [15:0] d;
    d = a - RAM_BASE;
    return d[11:1];
  endfunction

  logic [9:0]  pg;
  logic [15:0] ea;
  logic [15:0] word;
  logic [15:0] wnew;
  logic        mem_we;
  logic [10:0] mem_ix;
  logic        hit;
  logic        err;

  always_comb begin
    s_d         = s_q;
    s_d.rd_valid = 1'b0;
    s_d.flags   = flags_n;
    s_d.circ    = circ_a;
    s_d.bad     = bad_a;
    pg          = page_ptr0;
    ea          = acc_addr;
    hit         = 1'b0;
    err         = 1'b0;
    mem_we      = 1'b0;
    wnew        = acc_wdata;
    case (acc_page_sel)
      2'h0: pg = page_ptr0;
      2'h1: pg = page_ptr1;
      2'h2: pg = page_ptr2;
      default: pg = page_ptr3;
    endcase
    // bank base read at access time
    // word register n at base plus 2n, byte register n at base plus n
    if (acc_src == SRC_BANK) begin
      if (acc_size == ACC_BYTE)
        ea = s_q.bank + {12'h000, reg_num[3:1], 1'b0} + {15'h0, reg_num[0]};
      else
        ea = s_q.bank + {11'h000, reg_num[3:0], 1'b0};
    end
    mem_ix = widx(ea);
    word   = mem[mem_ix];
    // page 3 only for data accesses
    if (acc_src == SRC_DATA)
      hit = pg[1:0] == RAM_PAGE && pg[9:2] == 8'h00 && in_ram(ea);
    else
      hit = in_ram(ea);
    // word data even and in range
    if (acc_size == ACC_WORD && ea[0])
      err = 1'b1;
    if (acc_fetch && (ea > (acc_dbl ? CODE_TOP_2W : RAM_TOP_WORD)))
      err = 1'b1;
    if (acc_src == SRC_BANK && (ea - s_q.bank) > BANK_LAST_OFS)
      err = 1'b1;
    if (acc_size == ACC_BIT && !(bit_area(ea) || acc_src == SRC_BANK))
      err = 1'b1;
    if (acc_req && !(push || pop)) begin
      s_d.acc_err = err || !hit;
      s_d.ram_hit = hit && !err;
      s_d.bit_ok  = acc_size == ACC_BIT && !err;
      s_d.phys    = (acc_src == SRC_DATA) ? {pg[6:0], ea[13:0]}
                                          : {5'h00, ea};
      if (hit && !err) begin
        if (acc_wr) begin
          mem_we = 1'b1;
          // bit 0 even LSB, bit 15 odd MSB
          case (acc_size)
            ACC_BYTE: wnew = ea[0] ? {acc_wdata[7:0], word[7:0]}
                                   : {word[15:8], acc_wdata[7:0]};
            ACC_BIT: begin
              wnew = word;
              wnew[acc_bit] = acc_wdata[0];
            end
            default: wnew = acc_wdata;
          endcase
        end else begin
          s_d.rd_valid = 1'b1;
          case (acc_size)
            ACC_BYTE: s_d.rd_data = {8'h00, ea[0] ? word[15:8] : word[7:0]};
            ACC_BIT:  s_d.rd_data = {15'h0000, word[acc_bit]};
            default:  s_d.rd_data = word;
          endcase
        end
      end
    end
    if (push) begin
      s_d.sp = s_q.sp - 16'h0002;
      mem_ix = widx(s_q.sp - 16'h0002);
      wnew   = push_data;
      mem_we = in_ram(s_q.sp - 16'h0002);
      s_d.over = (s_q.sp - 16'h0002) < s_q.low_lim;
    end else if (pop) begin
      mem_ix = widx(s_q.sp);
      s_d.rd_valid = 1'b1;
      s_d.rd_data  = mem[widx(s_q.sp)];
      s_d.sp       = s_q.sp + 16'h0002;
      s_d.under    = (s_q.sp + 16'h0002) > s_q.high_lim;
    end
    if (sp_wr)
      s_d.sp = {sp_wdata[15:1], 1'b0};
    if (lim_wr) begin
      s_d.low_lim  = {low_lim_in[15:1], 1'b0};
      s_d.high_lim = {high_lim_in[15:1], 1'b0};
    end
    if (bank_switch) begin
      s_d.saved = s_q.bank;
      s_d.bank  = {bank_wdata[15:1], 1'b0};
    end else if (bank_wr)
      s_d.bank  = {bank_wdata[15:1], 1'b0};
  end

  // 3 KB word array in page 3
  always_ff @(posedge clk) begin
    if (mem_we)
      mem[mem_ix] <= wnew;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q          <= '0;
      s_q.sp       <= STK_TOP_STD + 16'h0002;
      s_q.low_lim  <= STK_BOT_256;
      s_q.high_lim <= STK_TOP_STD + 16'h0002;
      s_q.circ     <= 1'b1;
      s_q.bank     <= BANK_RESET;
    end else
      s_q <= s_d;
  end

  assign rd_valid          = s_q.rd_valid;
  assign rd_data           = s_q.rd_data;
  assign acc_err           = s_q.acc_err;
  assign ram_hit           = s_q.ram_hit;
  assign bit_ok            = s_q.bit_ok;
  assign stack_top_pointer = s_q.sp;
  assign stack_low_limit   = s_q.low_lim;
  assign stack_high_limit  = s_q.high_lim;
  assign stack_over        = s_q.over;
  assign stack_under       = s_q.under;
  assign stack_circ        = s_q.circ;
  assign size_bad          = s_q.bad;
  assign bank_base_pointer = s_q.bank;
  assign saved_bank        = s_q.saved;
  assign prot_flags        = s_q.flags;
  assign phys_addr         = s_q.phys;
endmodule
`default_nettype wire

// file: test/ram_stack_bank_map_properties.sv
// Port-level assertions for the RAM, stack and register bank map
`timescale 1ns/100ps
`default_nettype none
module ram_stack_bank_map_properties
  import ram_map_pkg::*;
(
  input wire logic        clk,               // Core clock
  input wire logic        rst,               // Sync reset
  input wire logic        acc_req,           // Access request
  input wire logic        acc_wr,            // Write
  input wire logic [1:0]  acc_src,           // Source kind
  input wire logic [1:0]  acc_size,          // Access size
  input wire logic        acc_fetch,         // Fetch
  input wire logic        acc_dbl,           // Two-word item
  input wire logic [15:0] acc_addr,          // Address
  input wire logic [1:0]  acc_page_sel,      // Page pointer index
  input wire logic [9:0]  page_ptr0,         // Page pointer 0
  input wire logic [9:0]  page_ptr1,         // Page pointer 1
  input wire logic        push,              // Push
  input wire logic        pop,               // Pop
  input wire logic        sp_wr,             // Stack pointer load
  input wire logic [2:0]  size_code,         // Stack size field
  input wire logic        bank_switch,       // Switch bank
  input wire logic [15:0] bank_wdata,        // New bank base
  input wire logic [32:0] flag_hw_set,       // Hardware sets
  input wire logic [32:0] flag_hw_clr,       // Hardware clears
  input wire logic        rd_valid,          // Read valid
  input wire logic        acc_err,           // Refused
  input wire logic        ram_hit,           // Reached RAM
  input wire logic [15:0] stack_top_pointer, // Stack pointer
  input wire logic        stack_circ,        // Circular allowed
  input wire logic        size_bad,          // Reserved code
  input wire logic [15:0] bank_base_pointer, // Bank base
  input wire logic [15:0] saved_bank,        // Saved base
  input wire logic [32:0] prot_flags         // Protected flags
);
  logic lone;
  logic in_ram;
  // Push or pop in the same cycle swallows the access
  assign lone = acc_req && !push && !pop;
  assign in_ram = acc_addr >= RAM_BASE && acc_addr <= RAM_TOP_WORD;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_good_rd;
    lone && !acc_wr && !acc_fetch && acc_size == 2'h1 && !acc_addr[0]
      && in_ram && (acc_src == 2'h1 || (acc_src == 2'h0
      && acc_page_sel == 2'h0 && page_ptr0 == 10'h3));
  endsequence
  sequence s_push;
    push && !sp_wr;
  endsequence
  sequence s_pop;
    pop && !push && !sp_wr;
  endsequence
  a_read_answered: assert property (
    s_good_rd |=> rd_valid && ram_hit && !acc_err)
    else $error("good read not answered");
  a_valid_cause: assert property (
    rd_valid |-> $past(acc_req && !acc_wr || pop))
    else $error("read valid without request");
  a_odd_refused: assert property (
    lone && acc_size == 2'h1 && acc_addr[0] && acc_src != 2'h3 |=> acc_err)
    else $error("odd word access accepted");
  a_page_refused: assert property (
    lone && acc_src == 2'h0 && acc_page_sel == 2'h1 && page_ptr1 != 10'h3
    |=> acc_err && !ram_hit)
    else $error("wrong page reached RAM");
  a_dbl_limit: assert property (
    lone && acc_fetch && acc_dbl && acc_addr > CODE_TOP_2W |=> acc_err)
    else $error("two-word fetch past limit accepted");
  a_push_down: assert property (
    s_push |=> stack_top_pointer == $past(stack_top_pointer) - 16'h2)
    else $error("push did not step down by two");
  a_pop_up: assert property (
    s_pop |=> stack_top_pointer == $past(stack_top_pointer) + 16'h2)
    else $error("pop did not step up by two");
  a_size_flags: assert property (
    1'b1 |=> size_bad == $past(size_code == 3'h5 || size_code == 3'h6)
    && stack_circ == $past(size_code < 3'h5))
    else $error("size flags wrong");
  a_switch_saves: assert property (
    bank_switch |=> saved_bank == $past(bank_base_pointer)
    && bank_base_pointer == $past(bank_wdata))
    else $error("bank switch did not save base");
  a_hwset_wins: assert property (
    |flag_hw_set |=> (prot_flags & $past(flag_hw_set)) == $past(flag_hw_set))
    else $error("hardware set lost");
  a_hwclr_wins: assert property (
    |flag_hw_clr |=> (prot_flags & $past(flag_hw_clr & ~flag_hw_set)) == 33'h0)
    else $error("hardware clear lost");
endmodule
bind ram_stack_bank_map ram_stack_bank_map_properties u_props (
  .clk, .rst, .acc_req, .acc_wr, .acc_src, .acc_size, .acc_fetch, .acc_dbl,
  .acc_addr, .acc_page_sel, .page_ptr0, .page_ptr1, .push, .pop, .sp_wr,
  .size_code, .bank_switch, .bank_wdata, .flag_hw_set, .flag_hw_clr,
  .rd_valid, .acc_err, .ram_hit, .stack_top_pointer, .stack_circ, .size_bad,
  .bank_base_pointer, .saved_bank, .prot_flags
);
`default_nettype wire

// file: test/ram_stack_bank_map_bench.sv
// Self-checking bench for the RAM, stack and register bank map
`timescale 1ns/100ps
`default_nettype none
module ram_stack_bank_map_bench
  import ram_map_pkg::*;
;
  wire logic        acc_req, acc_wr, acc_fetch, acc_dbl;
  wire logic [1:0]  acc_src, acc_size, acc_page_sel;
  wire logic [3:0]  acc_bit;
  wire logic [4:0]  reg_num;
  wire logic [15:0] acc_addr, acc_wdata;
  logic      [50:0] acc_v = '0;
  logic             clk = 1'b0, rst = 1'b1, push = 1'b0, pop = 1'b0;
  logic             sp_wr = 1'b0, lim_wr = 1'b0, bank_wr = 1'b0;
  logic             bank_switch = 1'b0, flag_wr = 1'b0;
  logic      [2:0]  size_code = '0;
  logic      [9:0]  page_ptr0 = 10'h3, page_ptr1 = 10'h5;
  logic      [9:0]  page_ptr2 = 10'h3, page_ptr3 = 10'h3;
  logic      [15:0] push_data = '0, sp_wdata = '0, bank_wdata = '0;
  logic      [15:0] low_lim_in = '0, high_lim_in = '0;
  logic      [32:0] flag_wdata = '0, flag_sel = '0;
  logic      [32:0] flag_hw_set = '0, flag_hw_clr = '0, prot_flags;
  logic             rd_valid, acc_err, ram_hit, bit_ok, stack_over;
  logic             stack_under, stack_circ, size_bad;
  logic      [15:0] rd_data, stack_top_pointer, stack_low_limit;
  logic      [15:0] stack_high_limit, bank_base_pointer, saved_bank;
  logic      [20:0] phys_addr;
  logic             fe = 1'b0, db = 1'b0;
  logic      [3:0]  bt = '0;
  logic      [4:0]  rn = '0;
  logic      [1:0]  ps = '0;
  int               miscompares = 0, checks = 0, i;
  // One packed word keeps every qualifier of an access changing together
  assign {acc_req, acc_wr, acc_src, acc_size, acc_fetch, acc_dbl,
          acc_page_sel, acc_bit, reg_num, acc_addr, acc_wdata} = acc_v;
  ram_stack_bank_map DUT (
    .clk, .rst, .acc_req, .acc_wr, .acc_src, .acc_size, .acc_fetch,
    .acc_dbl, .acc_addr, .acc_page_sel, .acc_bit, .acc_wdata, .reg_num,
    .page_ptr0, .page_ptr1, .page_ptr2, .page_ptr3, .push, .pop,
    .push_data, .sp_wr, .sp_wdata, .size_code, .lim_wr, .low_lim_in,
    .high_lim_in, .bank_wr, .bank_switch, .bank_wdata, .flag_wr,
    .flag_wdata, .flag_sel, .flag_hw_set, .flag_hw_clr, .rd_valid,
    .rd_data, .acc_err, .ram_hit, .bit_ok, .stack_top_pointer,
    .stack_low_limit, .stack_high_limit, .stack_over, .stack_under,
    .stack_circ, .size_bad, .bank_base_pointer, .saved_bank, .prot_flags,
    .phys_addr
  );
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [32:0] e, g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Answer lands on the same edge that takes the request
  task automatic acc(input logic [1:0] s, z, input logic w,
                     input logic [15:0] a, d);
    @(posedge clk);
    acc_v <= {1'b1, w, s, z, fe, db, ps, bt, rn, a, d};
    @(posedge clk);
    acc_v[50] <= 1'b0;
    #1;
  endtask
  task automatic try(input logic [1:0] s, z, input logic f, b,
                     input logic [1:0] p, input logic [15:0] a, e);
    fe = f;
    db = b;
    ps = p;
    acc(s, z, 1'b0, a, 16'h0);
    chk("acc_err", e, acc_err);
  endtask
  task automatic stk(input logic u, o, input logic [15:0] d);
    @(posedge clk);
    push <= u;
    pop <= o;
    push_data <= d;
    @(posedge clk);
    push <= 1'b0;
    pop <= 1'b0;
    #1;
  endtask
  task automatic bank(input logic s, input logic [15:0] b);
    @(posedge clk);
    bank_wr <= !s;
    bank_switch <= s;
    bank_wdata <= b;
    @(posedge clk);
    bank_wr <= 1'b0;
    bank_switch <= 1'b0;
    #1;
  endtask
  task automatic flg(input logic [32:0] s, c, w, d);
    @(posedge clk);
    flag_hw_set <= s;
    flag_hw_clr <= c;
    flag_wr <= |w;
    flag_sel <= w;
    flag_wdata <= d;
    @(posedge clk);
    flag_hw_set <= '0;
    flag_hw_clr <= '0;
    flag_wr <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("sp", 16'hFC00, stack_top_pointer);
    chk("low", 16'hFA00, stack_low_limit);
    chk("high", 16'hFC00, stack_high_limit);
    chk("bank", 16'hFC00, bank_base_pointer);
    chk("circ", 1'b1, stack_circ);
    chk("flags", 33'h0, prot_flags);
    acc(2'h0, 2'h1, 1'b1, 16'hFA00, 16'hA55A);
    acc(2'h0, 2'h1, 1'b0, 16'hFA00, 16'h0);
    chk("rd_data", 16'hA55A, rd_data);
    chk("rd_valid", 1'b1, rd_valid);
    chk("phys", 21'h00FA00, phys_addr);
    acc(2'h0, 2'h1, 1'b1, 16'hFA01, 16'h0BAD);
    acc(2'h0, 2'h1, 1'b0, 16'hFA00, 16'h0);
    chk("rd_data", 16'hA55A, rd_data);
    acc(2'h0, 2'h1, 1'b1, 16'hFD00, 16'h8001);
    for (i = 0; i < 16; i++) begin
      bt = i[3:0];
      acc(2'h0, 2'h2, 1'b0, 16'hFD00, 16'h0);
      chk("bit", (16'h8001 >> i) & 1, rd_data[0]);
    end
    try(2'h0, 2'h1, 1'b0, 1'b0, 2'h1, 16'hFA00, 1'b1);
    try(2'h0, 2'h1, 1'b0, 1'b0, 2'h2, 16'hFA00, 1'b0);
    try(2'h1, 2'h1, 1'b0, 1'b0, 2'h1, 16'hFA00, 1'b0);
    chk("ram_hit", 1'b1, ram_hit);
    try(2'h0, 2'h1, 1'b1, 1'b0, 2'h0, 16'hFDFE, 1'b0);
    try(2'h0, 2'h1, 1'b1, 1'b1, 2'h0, 16'hFDFE, 1'b1);
    try(2'h0, 2'h1, 1'b1, 1'b1, 2'h0, 16'hFDFC, 1'b0);
    try(2'h0, 2'h1, 1'b1, 1'b0, 2'h0, 16'hFE00, 1'b1);
    try(2'h0, 2'h1, 1'b0, 1'b0, 2'h0, 16'hF1FE, 1'b1);
    try(2'h0, 2'h1, 1'b0, 1'b0, 2'h0, 16'hF200, 1'b0);
    try(2'h0, 2'h2, 1'b0, 1'b0, 2'h0, 16'hFCFE, 1'b1);
    try(2'h0, 2'h2, 1'b0, 1'b0, 2'h0, 16'hFF00, 1'b1);
    chk("bit_ok", 1'b1, bit_ok);
    try(2'h0, 2'h2, 1'b0, 1'b0, 2'h0, 16'hFE00, 1'b1);
    chk("bit_ok", 1'b0, bit_ok);
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      size_code <= i[2:0];
      @(posedge clk);
      #1;
      chk("circ", i < 5, stack_circ);
      chk("size_bad", i == 5 || i == 6, size_bad);
    end
    @(posedge clk);
    size_code <= 3'h0;
    lim_wr <= 1'b1;
    low_lim_in <= 16'hFBFC;
    high_lim_in <= 16'hFC00;
    @(posedge clk);
    lim_wr <= 1'b0;
    #1;
    chk("low", 16'hFBFC, stack_low_limit);
    chk("high", 16'hFC00, stack_high_limit);
    stk(1'b1, 1'b0, 16'h1234);
    stk(1'b1, 1'b0, 16'h5678);
    chk("over", 1'b0, stack_over);
    stk(1'b1, 1'b0, 16'h9ABC);
    chk("over", 1'b1, stack_over);
    stk(1'b0, 1'b1, 16'h0);
    chk("pop", 16'h9ABC, rd_data);
    stk(1'b0, 1'b1, 16'h0);
    chk("sp", 16'hFBFE, stack_top_pointer);
    chk("under", 1'b0, stack_under);
    acc(2'h0, 2'h1, 1'b0, 16'hFBFE, 16'h0);
    chk("stack_ram", 16'h1234, rd_data);
    @(posedge clk);
    sp_wr <= 1'b1;
    sp_wdata <= 16'hFC01;
    push <= 1'b1;
    @(posedge clk);
    sp_wr <= 1'b0;
    push <= 1'b0;
    #1;
    chk("sp", 16'hFC00, stack_top_pointer);
    stk(1'b0, 1'b1, 16'h0);
    chk("under", 1'b1, stack_under);
    bank(1'b0, 16'hFC40);
    rn = 5'h03;
    acc(2'h3, 2'h1, 1'b1, 16'h0, 16'hBEEF);
    rn = 5'h0F;
    acc(2'h3, 2'h1, 1'b1, 16'h0, 16'hCAFE);
    acc(2'h0, 2'h1, 1'b0, 16'hFC46, 16'h0);
    chk("r3", 16'hBEEF, rd_data);
    acc(2'h0, 2'h1, 1'b0, 16'hFC5E, 16'h0);
    chk("r15", 16'hCAFE, rd_data);
    rn = 5'h02;
    acc(2'h3, 2'h1, 1'b1, 16'h0, 16'h1100);
    rn = 5'h05;
    acc(2'h3, 2'h0, 1'b1, 16'h0, 16'h0077);
    rn = 5'h04;
    acc(2'h3, 2'h0, 1'b1, 16'h0, 16'h0033);
    acc(2'h0, 2'h1, 1'b0, 16'hFC44, 16'h0);
    chk("r2", 16'h7733, rd_data);
    rn = 5'h03;
    bt = 4'hF;
    acc(2'h3, 2'h2, 1'b0, 16'h0, 16'h0);
    chk("reg_bit", 1'b1, rd_data[0]);
    acc(2'h0, 2'h1, 1'b1, 16'hFC86, 16'h4242);
    bank(1'b1, 16'hFC80);
    chk("saved", 16'hFC40, saved_bank);
    acc(2'h3, 2'h1, 1'b0, 16'h0, 16'h0);
    chk("r3", 16'h4242, rd_data);
    flg(33'h1, 33'h0, 33'h0, 33'h0);
    flg(33'h0, 33'h0, 33'h2, 33'h2);
    chk("flags", 33'h3, prot_flags);
    flg(33'h1, 33'h2, 33'h3, 33'h2);
    chk("flags", 33'h1, prot_flags);
    flg(33'h0, 33'h0, 33'h100000000, 33'h100000000);
    chk("flags", 33'h100000001, prot_flags);
    results;
  end
endmodule
`default_nettype wire
